// file: logic/reset_and_external_memory_port.sv
// Reset sequencer, port 0 handshake and external bus engine behind Wishbone.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module reset_and_external_memory_port
  import emport_pkg::*;
#(
  parameter int POR_CYCLES = POR_CLKS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Reset pin, strap and internal reset sources.
  input  wire logic        reset_pin_n_i,
  output logic             reset_pin_n_o,
  output logic             reset_pin_oe_o,
  input  wire logic        external_program_strap_i,
  input  wire logic        watchdog_timeout_i,
  input  wire logic        stop_recovery_i,
  // Core side.
  output logic             core_rst_o,
  output logic             dsp_rst_o,
  output logic             core_fetch_start_o,
  output logic [15:0]      core_fetch_addr_o,
  output logic [15:0]      dsp_vector_addr_o,
  output logic             rom_disable_o,
  input  wire logic [15:0] core_fetch_query_i,
  output logic             core_fetch_external_o,
  // External memory bus.
  output logic             address_strobe_n_o,
  output logic             data_strobe_n_o,
  output logic             read_write_o,
  output logic             strobe_oe_o,
  input  wire logic [7:0]  address_data_port_i,
  output logic [7:0]       address_data_port_o,
  output logic             address_data_port_oe_o,
  input  wire logic [7:0]  high_address_port_i,
  output logic [7:0]       high_address_port_o,
  output logic [1:0]       high_address_port_oe_o,
  // Port 0 handshake lines on port 3.
  input  wire logic        hs_p32_i,
  output logic             hs_p35_o
);

  typedef enum logic [2:0] {BUS_IDLE, BUS_ADDR, BUS_GAP, BUS_DATA, BUS_END} bus_state_t;

  // ==========================================================================
  // Helpers.

  // Byte-lane merge for a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

  // True when a core address lies outside internal ROM.
  function automatic logic is_external(input logic [15:0] addr, input logic external_program_strap);
    is_external = external_program_strap ? (addr >= EXTERNAL_PROGRAM_STRAP_EXT_BASE) : (addr >= ROM_EXT_BASE);
  endfunction : is_external

  // ==========================================================================
  // Two-stage synchronisers on every pin input.
  logic [1:0] rst_pin_sync;
  logic [1:0] strap_sync;
  logic [1:0] p32_sync;
  logic       p32_prev;
  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rst_pin_sync <= {rst_pin_sync[0], reset_pin_n_i};
      strap_sync   <= {strap_sync[0], external_program_strap_i};
      p32_sync     <= {p32_sync[0], hs_p32_i};
      p32_prev     <= p32_sync[1];
      p1_meta      <= address_data_port_i;
      p1_sync      <= p1_meta;
      p0_meta      <= high_address_port_i;
      p0_sync      <= p0_meta;
    end
  end

  // ==========================================================================
  // Reset sequencing.
  localparam int POR_W = $clog2(POR_CYCLES + 1);

  logic [2:0]       filt_cnt;
  logic [4:0]       stretch_cnt;
  logic [POR_W-1:0] por_cnt;
  logic [3:0]       fetch_cnt;
  logic             core_rst_reg;
  logic             dsp_rst_reg;
  logic             fetch_start_reg;
  rst_cause_t       cause_reg;
  logic             pin_drive;
  logic             pin_low;
  logic             pin_trigger;
  logic             full_clear;
  logic             any_clear;

  // The filter ignores the block's own drive on the pin.
  assign pin_drive   = (por_cnt != '0);
  assign pin_low     = ~rst_pin_sync[1] & ~pin_drive;
  assign pin_trigger = pin_low && (filt_cnt == 3'(FILTER_CLKS));
  // Stop recovery spares the preserved mode registers.
  assign full_clear  = rst_i | (core_rst_reg & (cause_reg != CAUSE_STOP));
  assign any_clear   = rst_i | core_rst_reg;

  // Counts consecutive low samples, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt <= '0;
    end else if (ce_i) begin
      if (!pin_low) begin
        filt_cnt <= '0;
      end else if (filt_cnt != 3'(FILTER_CLKS)) begin
        filt_cnt <= filt_cnt + 3'h1;
      end
    end
  end

  // Pin drive interval for power-on and watchdog resets.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_cnt <= POR_W'(POR_CYCLES);
    end else if (ce_i) begin
      if (watchdog_timeout_i && !core_rst_reg) begin
        por_cnt <= POR_W'(POR_CYCLES);
      end else if (pin_drive) begin
        por_cnt <= por_cnt - POR_W'(1);
      end
    end
  end

  // Core reset latch and stretch; a long pin low extends it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rst_reg <= 1'b1;
      dsp_rst_reg  <= 1'b1;
      cause_reg    <= CAUSE_POWER;
      stretch_cnt  <= 5'(STRETCH_CLKS);
    end else if (ce_i) begin
      if (!core_rst_reg) begin
        if (pin_trigger) begin
          core_rst_reg <= 1'b1;
          dsp_rst_reg  <= 1'b1;
          cause_reg    <= CAUSE_PIN;
          stretch_cnt  <= 5'(STRETCH_CLKS);
        end else if (watchdog_timeout_i) begin
          core_rst_reg <= 1'b1;
          cause_reg    <= CAUSE_WDOG;
          stretch_cnt  <= 5'(STRETCH_CLKS);
        end else if (stop_recovery_i) begin
          core_rst_reg <= 1'b1;
          cause_reg    <= CAUSE_STOP;
          stretch_cnt  <= 5'(STRETCH_CLKS);
        end
      end else if (stretch_cnt != 5'h00) begin
        stretch_cnt <= stretch_cnt - 5'h01;
      end else if (!pin_low && !pin_drive) begin
        core_rst_reg <= 1'b0;
        dsp_rst_reg  <= 1'b0;
      end
    end
  end

  // First fetch a fixed delay after the stretched reset ends.
  always_ff @(posedge clk_i) begin
    if (any_clear) begin
      fetch_cnt       <= 4'(FETCH_DELAY_CLKS);
      fetch_start_reg <= 1'b0;
    end else if (ce_i) begin
      fetch_start_reg <= (fetch_cnt == 4'h1);
      if (fetch_cnt != 4'h0) begin
        fetch_cnt <= fetch_cnt - 4'h1;
      end
    end
  end

  // Strap is caught during power-on reset.
  logic strap_reg;
  always_ff @(posedge clk_i) begin
    if (ce_i && rst_i) begin
      strap_reg <= strap_sync[1];
    end
  end

  assign reset_pin_n_o         = 1'b0;
  assign reset_pin_oe_o        = pin_drive;
  assign core_rst_o            = core_rst_reg;
  assign dsp_rst_o             = dsp_rst_reg;
  assign core_fetch_start_o    = fetch_start_reg;
  assign core_fetch_addr_o     = CORE_START_ADDR;
  assign dsp_vector_addr_o     = DSP_VECTOR_ADDR;
  // The signal core always runs from internal ROM.
  assign rom_disable_o         = strap_reg;
  assign core_fetch_external_o = is_external(core_fetch_query_i, strap_reg);

  // ==========================================================================
  // Registers.
  ctrl_t       ctrl_reg;
  logic [15:0] mode23_reg;
  logic [15:0] recov_reg;
  logic [15:0] mem_addr_reg;
  logic [7:0]  mem_wdata_reg;
  logic [7:0]  mem_rdata_reg;
  logic [7:0]  p0_out_reg;
  logic [7:0]  p0_latch_reg;
  logic        err_reg;
  logic        mem_write_reg;
  logic        dav_n_reg;
  logic        rdy_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  bus_state_t  state_reg;
  logic [3:0]  phase_cnt;
  logic        wb_hit;
  logic        wr_hit;
  logic        go_req;
  logic        go_ok;
  logic        hs_out_dir;
  logic        hs_in_dir;
  logic        p32_fell;

  assign wb_hit     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_hit     = wb_hit & wb_we_i;
  assign go_req     = wr_hit && wb_adr_i == OFS_MEM_CMD && wb_sel_i[0] && wb_dat_i[CMD_GO];
  assign go_ok      = go_req && state_reg == BUS_IDLE && ctrl_reg.p1_addr_mode;
  assign hs_out_dir = ctrl_reg.hs_en && ctrl_reg.p0_high == P0_OUT;
  assign hs_in_dir  = ctrl_reg.hs_en && ctrl_reg.p0_high == P0_IN;
  assign p32_fell   = p32_prev & ~p32_sync[1];

  // Preserved mode registers clear only on a full reset.
  always_ff @(posedge clk_i) begin
    if (full_clear) begin
      mode23_reg <= MODE23_RST;
      recov_reg  <= RECOV_RST;
    end else if (ce_i && wr_hit) begin
      if (wb_adr_i == OFS_MODE23) begin
        mode23_reg <= merge16(mode23_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == OFS_RECOV) begin
        recov_reg <= merge16(recov_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Control and address; the control reset value follows the strap.
  always_ff @(posedge clk_i) begin
    if (any_clear) begin
      ctrl_reg      <= strap_sync[1] ? CTRL_RST_EXTERNAL_PROGRAM_STRAP : CTRL_RST_ROM;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 8'h00;
      p0_out_reg    <= 8'h00;
    end else if (ce_i && wr_hit && wb_sel_i[0]) begin
      case (wb_adr_i)
        OFS_CTRL:     ctrl_reg      <= ctrl_t'(wb_dat_i[7:0]);
        OFS_P0_DATA:  p0_out_reg    <= wb_dat_i[7:0];
        OFS_MEM_DATA: mem_wdata_reg <= wb_dat_i[7:0];
        OFS_MEM_ADDR: mem_addr_reg  <= merge16(mem_addr_reg, wb_dat_i, wb_sel_i);
        default:      ;
      endcase
    end else if (ce_i && wr_hit && wb_adr_i == OFS_MEM_ADDR) begin
      mem_addr_reg <= merge16(mem_addr_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Sticky refusal flag; a new refusal wins over a write-one clear.
  always_ff @(posedge clk_i) begin
    if (any_clear) begin
      err_reg <= 1'b0;
    end else if (ce_i) begin
      if (go_req && !go_ok) begin
        err_reg <= 1'b1;
      end else if (wr_hit && wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[ST_ERR]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // Port 0 handshake; the upper nibble direction picks the role.
  always_ff @(posedge clk_i) begin
    if (any_clear) begin
      dav_n_reg    <= 1'b1;
      rdy_reg      <= 1'b1;
      p0_latch_reg <= 8'h00;
    end else if (ce_i) begin
      if (wr_hit && wb_adr_i == OFS_P0_DATA && wb_sel_i[0] && hs_out_dir) begin
        dav_n_reg <= 1'b0;
      end else if (!dav_n_reg && p32_sync[1]) begin
        dav_n_reg <= 1'b1;
      end
      if (hs_in_dir && rdy_reg && p32_fell) begin
        p0_latch_reg <= p0_sync;
        rdy_reg      <= 1'b0;
      end else if (wb_hit && !wb_we_i && wb_adr_i == OFS_P0_DATA) begin
        rdy_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Registered ack one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_reg <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          OFS_CTRL:     rdata_reg <= {24'h000000, ctrl_reg};
          OFS_STATUS:   rdata_reg <= {25'h0000000, core_rst_reg, hs_p35_o, cause_reg,
                                      strap_reg, err_reg, state_reg != BUS_IDLE};
          OFS_P0_DATA:  rdata_reg <= {24'h000000, hs_in_dir ? p0_latch_reg : p0_sync};
          OFS_MEM_ADDR: rdata_reg <= {16'h0000, mem_addr_reg};
          OFS_MEM_DATA: rdata_reg <= {24'h000000, mem_rdata_reg};
          OFS_MODE23:   rdata_reg <= {16'h0000, mode23_reg};
          OFS_RECOV:    rdata_reg <= {16'h0000, recov_reg};
          default:      rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================================
  // Bus cycle: address, gap, data, recovery.
  always_ff @(posedge clk_i) begin
    if (any_clear) begin
      state_reg     <= BUS_IDLE;
      phase_cnt     <= 4'h0;
      mem_write_reg <= 1'b0;
      mem_rdata_reg <= 8'h00;
    end else if (ce_i) begin
      case (state_reg)
        BUS_IDLE: begin
          if (go_ok) begin
            state_reg     <= BUS_ADDR;
            phase_cnt     <= 4'(AS_CLKS - 1);
            mem_write_reg <= wb_dat_i[CMD_WRITE];
          end
        end
        BUS_ADDR: begin
          if (phase_cnt == 4'h0) begin
            state_reg <= BUS_GAP;
          end else begin
            phase_cnt <= phase_cnt - 4'h1;
          end
        end
        BUS_GAP: begin
          state_reg <= BUS_DATA;
          phase_cnt <= ctrl_reg.ext_timing ? 4'(DS_CLKS + EXT_WAIT_CLKS - 1)
                                           : 4'(DS_CLKS - 1);
        end
        BUS_DATA: begin
          if (phase_cnt == 4'h0) begin
            state_reg <= BUS_END;
            if (!mem_write_reg) begin
              mem_rdata_reg <= p1_sync;
            end
          end else begin
            phase_cnt <= phase_cnt - 4'h1;
          end
        end
        BUS_END: state_reg <= BUS_IDLE;
        default: state_reg <= BUS_IDLE;
      endcase
    end
  end

  // Strobes decode from the state, idle through a stretch.
  assign address_strobe_n_o     = ~(state_reg == BUS_ADDR);
  assign data_strobe_n_o        = ~(state_reg == BUS_DATA);
  assign read_write_o           = ~(mem_write_reg && state_reg != BUS_IDLE);
  assign strobe_oe_o            = ~ctrl_reg.bus_float;
  assign address_data_port_o    = (state_reg == BUS_ADDR) ? mem_addr_reg[7:0]
                                                          : mem_wdata_reg;
  // Write data drives from the gap, so it is settled when the data strobe falls.
  assign address_data_port_oe_o = ~ctrl_reg.bus_float && (state_reg == BUS_ADDR ||
                                  (mem_write_reg && state_reg != BUS_IDLE));

  // ==========================================================================
  // Port 0 nibbles; handshake mode copies the upper direction down.
  p0_mode_t nib_mode [2];
  assign nib_mode[1] = ctrl_reg.p0_high;
  assign nib_mode[0] = (ctrl_reg.hs_en && ctrl_reg.p0_high != P0_ADDR) ? ctrl_reg.p0_high
                                                                       : ctrl_reg.p0_low;

  for (genvar n = 0; n < 2; n++) begin : g_nibble
    assign high_address_port_o[4*n +: 4] = (nib_mode[n] == P0_ADDR)
                                           ? mem_addr_reg[8 + 4*n +: 4]
                                           : p0_out_reg[4*n +: 4];
    assign high_address_port_oe_o[n]     = (nib_mode[n] == P0_OUT) ||
                                           (nib_mode[n] == P0_ADDR && !ctrl_reg.bus_float);
  end

  assign hs_p35_o = hs_out_dir ? dav_n_reg : (hs_in_dir ? rdy_reg : 1'b1);

endmodule : reset_and_external_memory_port
`default_nettype wire

// file: inc/emport_pkg.sv
// Constants, types and register map of the external memory port.
//
// Overview of operation
// - Ignore reset pin lows shorter than five clocks.
// - Fifth clock latches core reset, hold 18+.
// - Core fetch starts at 000C after release.
// - Stop recovery keeps watchdog, recovery, port modes.
// - Drive reset pin low during power/watchdog resets.
// - Four reset sources; pin resets both cores.
// - Pin driven low 2000 clocks; signal core vector 0FFC.
// - Strap high disables core ROM; signal core internal.
// - Read/write line high reads, low writes.
// - Address strobe pulse per cycle, address out.
// - Software floats strobes, read/write, port 1, port 0 address nibbles.
// - Data strobe once per transfer, write data early.
// - Port 0 nibbles: I/O or high address.
// - Handshake on P32/P35, upper nibble sets direction.
// - Address 11-8 low nibble, 15-8 both nibbles.
// - Port 0 mode register selects nibble use.
// - Strap reset: port 0 address, extended timing.
// - ROM mode reset leaves port 0 inputs.
// - External fetch above 24575 or from 12.
// - Port 1 must be address/data before access.
package emport_pkg;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS    = 5;
  localparam int FILTER_CLKS      = 4;
  localparam int STRETCH_CLKS     = 18;
  localparam int FETCH_DELAY_CLKS = 5;
  localparam int POR_TIME_NS      = 10000;
  localparam int POR_CLKS         = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AS_CLKS          = 1;
  localparam int DS_CLKS          = 3;
  localparam int EXT_WAIT_CLKS    = 4;

  // ==========================================================================
  // Addresses seen by the cores.
  localparam logic [15:0] CORE_START_ADDR  = 16'h000C;
  localparam logic [15:0] DSP_VECTOR_ADDR  = 16'h0FFC;
  localparam logic [15:0] ROM_EXT_BASE     = 16'h6000;
  localparam logic [15:0] EXTERNAL_PROGRAM_STRAP_EXT_BASE = 16'h000C;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_P0_DATA  = 8'h08;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h0C;
  localparam logic [7:0] OFS_MEM_DATA = 8'h10;
  localparam logic [7:0] OFS_MEM_CMD  = 8'h14;
  localparam logic [7:0] OFS_MODE23   = 8'h18;
  localparam logic [7:0] OFS_RECOV    = 8'h1C;

  // Field positions of status and command words.
  localparam int ST_BUSY    = 0;
  localparam int ST_ERR     = 1;
  localparam int ST_STRAP   = 2;
  localparam int ST_CAUSE   = 3;
  localparam int ST_HS_LINE = 5;
  localparam int ST_CORE_RST = 6;
  localparam int CMD_GO     = 0;
  localparam int CMD_WRITE  = 1;

  typedef enum logic [1:0] {P0_IN = 2'h0, P0_OUT = 2'h1, P0_ADDR = 2'h2} p0_mode_t;
  typedef enum logic [1:0] {CAUSE_POWER, CAUSE_WDOG, CAUSE_STOP, CAUSE_PIN} rst_cause_t;

  // Control word, low byte of control.
  typedef struct packed {
    logic     hs_en;
    logic     p1_addr_mode;
    logic     bus_float;
    logic     ext_timing;
    p0_mode_t p0_high;
    p0_mode_t p0_low;
  } ctrl_t;

  localparam ctrl_t CTRL_RST_ROM     = '{1'b0, 1'b0, 1'b0, 1'b0, P0_IN, P0_IN};
  localparam ctrl_t CTRL_RST_EXTERNAL_PROGRAM_STRAP = '{1'b0, 1'b1, 1'b0, 1'b1, P0_ADDR, P0_ADDR};
  localparam logic [15:0] MODE23_RST = 16'h0000;
  localparam logic [15:0] RECOV_RST  = 16'h0000;

endpackage : emport_pkg

// file: test/emport_asserts.sv
// Concurrent checks on reset sequencing and the external bus.
`timescale 1ns/10ps
`default_nettype none
module emport_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        reset_pin_n_o,
  input wire logic        reset_pin_oe_o,
  input wire logic        core_rst_o,
  input wire logic        core_fetch_start_o,
  input wire logic        rom_disable_o,
  input wire logic [15:0] core_fetch_query_i,
  input wire logic        core_fetch_external_o,
  input wire logic        address_strobe_n_o,
  input wire logic        data_strobe_n_o,
  input wire logic        read_write_o,
  input wire logic        strobe_oe_o,
  input wire logic        address_data_port_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Cycles core reset has stood; saturating so it never wraps.
  logic [7:0] held_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || !core_rst_o) held_reg <= 8'h00;
    else if (held_reg != 8'hFF) held_reg <= held_reg + 8'h01;
  end
  // ==========================================================================
  // Reset sequencing.
  property p_stretch; $fell(core_rst_o) |-> held_reg >= 8'h12; endproperty
  a_stretch: assert property (p_stretch) else $error("Core reset too short.");
  property p_fetch; $fell(core_rst_o) |-> ##[5:10] core_fetch_start_o; endproperty
  a_fetch: assert property (p_fetch) else $error("Fetch start missing.");
  property p_pin; $fell(rst_i) |-> reset_pin_oe_o && !reset_pin_n_o && core_rst_o; endproperty
  a_pin: assert property (p_pin) else $error("Pin not driven.");
  property p_quiet; core_rst_o |-> address_strobe_n_o && data_strobe_n_o && read_write_o; endproperty
  a_quiet: assert property (p_quiet) else $error("Bus active in reset.");
  // ==========================================================================
  // External bus timing and fetch decode.
  property p_ext; core_fetch_external_o == (core_fetch_query_i >=
    (rom_disable_o ? 16'h000C : 16'h6000)); endproperty
  a_ext: assert property (p_ext) else $error("Fetch decode wrong.");
  property p_as; $fell(address_strobe_n_o) && strobe_oe_o |->
    address_data_port_oe_o ##1 address_strobe_n_o; endproperty
  a_as: assert property (p_as) else $error("Address strobe wrong.");
  property p_ds; $fell(data_strobe_n_o) |->
    $past(address_strobe_n_o, 2) == 1'b0 ##[3:7] $rose(data_strobe_n_o); endproperty
  a_ds: assert property (p_ds) else $error("Data strobe wrong.");
  property p_rw; $fell(address_strobe_n_o) && !read_write_o |=> !read_write_o [*5]; endproperty
  a_rw: assert property (p_rw) else $error("Write line released early.");
endmodule : emport_asserts
bind reset_and_external_memory_port emport_asserts u_chk (.*);
`default_nettype wire

// file: test/ext_mem_model.sv
// Byte memory on the multiplexed external bus.
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input  wire logic       clk_i,
  input  wire logic       as_n_i,
  input  wire logic       ds_n_i,
  input  wire logic       rw_i,
  input  wire logic [7:0] lo_i,
  input  wire logic [7:0] hi_i,
  output logic      [7:0] drv_o
);
  // ==========================================================================
  // Storage, latched address and the last byte put on the bus.
  logic [7:0]  mem [0:65535];
  logic [15:0] adr_reg  = 16'h0000;
  logic [7:0]  last_reg = 8'h00;
  // Values are taken at every rising clock edge while a strobe is low.
  always @(posedge clk_i) begin
    if (!as_n_i) adr_reg <= {hi_i, lo_i};
    if (!ds_n_i && !rw_i) mem[adr_reg] <= lo_i;
    if (!ds_n_i && rw_i) last_reg <= mem[adr_reg];
  end
  // A released bus shows the inverse of the last byte.
  assign drv_o = (!ds_n_i && rw_i) ? mem[adr_reg] : ~last_reg;
endmodule : ext_mem_model
`default_nettype wire

// file: test/reset_and_external_memory_port_tb.sv
// Self-checking bench for the reset and external memory port.
`timescale 1ns/10ps
`default_nettype none
module reset_and_external_memory_port_tb;
  import emport_pkg::*;
  // ==========================================================================
  // Stimulus and observed outputs.
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        pull = 1'b0, strap = 1'b0, wdog = 1'b0, stop = 1'b0;
  logic [7:0]  adr = 8'h00, drv, address_data_port_o, high_address_port_o;
  logic [31:0] dat = 32'h0, rd, wb_dat_o, seed = 32'h62DC, fq = 32'h62DC;
  logic        wb_ack_o, reset_pin_oe_o, core_rst_o, dsp_rst_o, rom_disable_o;
  logic        address_strobe_n_o, data_strobe_n_o, read_write_o, strobe_oe_o;
  logic        address_data_port_oe_o;
  logic [1:0]  high_address_port_oe_o;
  logic [15:0] core_fetch_addr_o, dsp_vector_addr_o;
  int          errors = 0, total_checks = 0;
  // Open-drain reset pin: low while either side pulls it.
  reset_and_external_memory_port #(.POR_CYCLES(8)) uut (.clk_i, .rst_i, .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .reset_pin_n_i(~(reset_pin_oe_o | pull)),
    .reset_pin_n_o(), .reset_pin_oe_o, .external_program_strap_i(strap),
    .watchdog_timeout_i(wdog), .stop_recovery_i(stop), .core_rst_o, .dsp_rst_o,
    .core_fetch_start_o(), .core_fetch_addr_o, .dsp_vector_addr_o, .rom_disable_o,
    .core_fetch_query_i(fq[15:0]), .core_fetch_external_o(), .address_strobe_n_o,
    .data_strobe_n_o, .read_write_o, .strobe_oe_o,
    .address_data_port_i(address_data_port_oe_o ? address_data_port_o : drv),
    .address_data_port_o, .address_data_port_oe_o, .high_address_port_i(8'hA5),
    .high_address_port_o, .high_address_port_oe_o, .hs_p32_i(1'b0), .hs_p35_o());
  ext_mem_model mdl (.clk_i, .as_n_i(address_strobe_n_o), .ds_n_i(data_strobe_n_o),
    .rw_i(read_write_o), .lo_i(address_data_port_o), .hi_i(high_address_port_o),
    .drv_o(drv));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) fq <= lfsr(fq);
  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic finish_test();
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk
  task automatic limit(input int n, input int m);
    if (n >= m) begin
      errors++;
      finish_test();
    end
  endtask : limit
  // Ack and read data are taken at the rising edge that samples ack high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
    limit(n, 20);
  endtask : wb
  task automatic wrst(input logic v);
    int n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (core_rst_o !== v && n < 200);
    limit(n, 200);
  endtask : wrst
  task automatic busy_wait();
    int n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 20);
    limit(n, 20);
  endtask : busy_wait
  task automatic xfer(input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, OFS_MEM_ADDR, {16'h0, a});
    wb(1'b1, OFS_MEM_DATA, {24'h0, d});
    wb(1'b1, OFS_MEM_CMD, 32'h3);
    busy_wait();
    chk("ext_write", {24'h0, d}, {24'h0, mdl.mem[a]});
    chk("p0_addr", {24'h0, a[15:8]}, {24'h0, high_address_port_o});
    wb(1'b1, OFS_MEM_DATA, 32'h0);
    wb(1'b1, OFS_MEM_CMD, 32'h1);
    busy_wait();
    wb(1'b0, OFS_MEM_DATA, 32'h0);
    chk("ext_read", {24'h0, d}, rd);
  endtask : xfer
  task automatic pulse(input logic [2:0] s, input int k);
    @(posedge clk_i);
    {pull, wdog, stop} <= s;
    repeat (k) @(posedge clk_i);
    {pull, wdog, stop} <= 3'b000;
    repeat (3) @(negedge clk_i);
  endtask : pulse
  // ==========================================================================
  // ROM mode, transfers, refusals, resets, then strap mode.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wrst(1'b0);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_rom", 32'h0, rd);
    chk("p0_oe", 32'h0, {30'h0, high_address_port_oe_o});
    chk("start", 32'h000C, {16'h0, core_fetch_addr_o});
    chk("dsp_vec", 32'h0FFC, {16'h0, dsp_vector_addr_o});
    wb(1'b1, OFS_CTRL, 32'h4A);
    xfer(16'hFFFF, 8'h00);
    xfer(16'h0000, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      xfer(seed[15:0], seed[23:16]);
    end
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, OFS_CTRL, 32'h85);
    wb(1'b1, OFS_P0_DATA, 32'h0);
    wb(1'b1, OFS_MEM_CMD, 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("refused", 32'h2, rd & 32'h3);
    chk("dav", 32'h0, {31'h0, rd[ST_HS_LINE]});
    wb(1'b1, OFS_CTRL, 32'h6A);
    chk("float", 32'h0, {31'h0, strobe_oe_o});
    pulse(3'b100, 3);
    chk("short_pin", 32'h0, {31'h0, core_rst_o});
    pulse(3'b100, 10);
    chk("pin_core", 32'h1, {31'h0, core_rst_o});
    chk("pin_dsp", 32'h1, {31'h0, dsp_rst_o});
    wrst(1'b0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("cause", 32'h3, {30'h0, rd[4:3]});
    pulse(3'b010, 1);
    chk("wd_core", 32'h1, {31'h0, core_rst_o});
    chk("wd_dsp", 32'h0, {31'h0, dsp_rst_o});
    chk("wd_pin", 32'h1, {31'h0, reset_pin_oe_o});
    wrst(1'b0);
    seed = lfsr(seed);
    wb(1'b1, OFS_MODE23, {16'h0, seed[15:0]});
    pulse(3'b001, 1);
    wrst(1'b0);
    wb(1'b0, OFS_MODE23, 32'h0);
    chk("mode23", {16'h0, seed[15:0]}, rd);
    @(posedge clk_i);
    {strap, rst_i} <= 2'b11;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wrst(1'b0);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_external_program_strap", 32'h5A, rd);
    chk("rom_off", 32'h1, {31'h0, rom_disable_o});
    xfer(16'h1234, 8'h5C);
    wb(1'b1, OFS_CTRL, 32'h4A);
    xfer(16'hABCD, 8'hC3);
    finish_test();
  end
endmodule : reset_and_external_memory_port_tb
`default_nettype wire
